// File: design/tta_top.sv
// Throttle input monitor: pin routing, fan override, timer and limit alert
// What this block does
// - Alert output off after reset; config bits route it to pin 14 or 5.
// - Config bit 1 makes pin 9 the active-low throttle input, enables monitor.
// - Full-speed bit forces running fans to full duty while throttle is low.
// - Override only applies to fans already running.
// - Full-speed bit clear: throttle never changes fan drive.
// - Timer runs while asserted, pauses when negated, accumulates.
// - Timer saturates at full scale until a read clears it.
// - Reading the timer returns its value then clears it.
// - Bit 0 marks first assertion; past 45.52 ms LSB weighs 22.76 ms.
// - Read during assertion clears, sets bit 0 again, keeps counting.
// - Read during assertion with limit zero sets the limit flag again.
// - Timer above limit sets status bit 5 and raises the alert.
// - Limit zero alerts on first assertion; limit one after 45.52 ms.
// - Mask bit 5 blocks the alert but the flag still sets.
// - Status flags stick until condition ends and status is read.
// - Alert stays low while unmasked flag set, until status read.
module tta_top #(
   parameter int LSB_CYC = tta_pkg::LSB_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        throttle_pin_in,
   input  wire logic [23:0] fan_duty_in,
   output logic      [23:0] fan_duty_out,
   output logic             alert_pin5_n,
   output logic             alert_pin14_n,
   output logic             throttle_active
);
   logic [7:0] cfg3;
   logic [7:0] cfg4;
   logic [7:0] limit;
   logic [7:0] mask2;
   logic [7:0] status2;
   logic [7:0] fan_ctrl;
   logic [7:0] next_cfg3;
   logic [7:0] next_cfg4;
   logic [7:0] next_limit;
   logic [7:0] next_mask2;
   logic [7:0] next_status2;
   logic [7:0] next_fan_ctrl;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic [23:0] next_fan_duty;
   logic        next_alert5_n;
   logic        next_alert14_n;
   logic        sync1;
   logic        sync2;
   logic        asserted;
   logic        over;
   logic        reading;
   logic        status_read;
   logic        wr;
   logic [9:0]  widx;
   tta_bus_if   tbus ();

   // Two-flop synchroniser; only sync2 is looked at
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
      end else if (ce) begin
         sync1 <= throttle_pin_in;
         sync2 <= sync1;
      end
   end

   assign asserted = cfg3[tta_pkg::BIT_THR_ENABLE] && !sync2;

   // APB: one wait state, pready comes in the cycle after the first access cycle
   assign widx = paddr[11:tta_pkg::ADDR_SHIFT];
   assign wr   = psel && penable && !pready && pwrite;
   assign reading = psel && penable && !pready && !pwrite;
   assign tbus.timer_read = reading && widx == 10'(tta_pkg::IDX_TIMER);
   assign status_read =
      reading && widx == 10'(tta_pkg::IDX_STATUS_TWO);

   tta_accum #(.LSB_CYC(LSB_CYC)) u_accum (
      .mclk     (mclk),
      .resetn   (resetn),
      .ce       (ce),
      .asserted (asserted),
      .bus      (tbus)
   );

   // Limit 0 fires on any set timer code, limit n when timer exceeds n
   assign over = asserted && (limit == 8'h00 ?
                 tbus.count != 8'h00 : tbus.count > limit)
                 || (tbus.timer_read && asserted && limit == 8'h00);

   always_comb begin
      next_cfg3    = cfg3;
      next_cfg4    = cfg4;
      next_limit   = limit;
      next_mask2   = mask2;
      next_fan_ctrl = fan_ctrl;
      next_status2 = status2;
      if (wr) begin
         case (widx)
            10'(tta_pkg::IDX_CONFIG_THREE): next_cfg3 = pwdata[7:0];
            10'(tta_pkg::IDX_CONFIG_FOUR):  next_cfg4 = pwdata[7:0];
            10'(tta_pkg::IDX_LIMIT):        next_limit = pwdata[7:0];
            10'(tta_pkg::IDX_MASK_TWO):     next_mask2 = pwdata[7:0];
            10'(tta_pkg::IDX_FAN_CTRL):     next_fan_ctrl = pwdata[7:0];
            default: ;
         endcase
      end
      // Read clears only if condition has gone; set wins over clear
      if (status_read && !over)
         next_status2[tta_pkg::BIT_LIMIT_FLAG] = 1'b0;
      if (over)
         next_status2[tta_pkg::BIT_LIMIT_FLAG] = 1'b1;
   end

   always_comb begin
      next_prdata  = 32'h0;
      next_pslverr = 1'b0;
      next_pready  = psel && penable && !pready;
      if (psel && penable && !pready && !pwrite) begin
         case (widx)
            10'(tta_pkg::IDX_CONFIG_THREE): next_prdata[7:0] = cfg3;
            10'(tta_pkg::IDX_CONFIG_FOUR):  next_prdata[7:0] = cfg4;
            10'(tta_pkg::IDX_LIMIT):        next_prdata[7:0] = limit;
            10'(tta_pkg::IDX_MASK_TWO):     next_prdata[7:0] = mask2;
            10'(tta_pkg::IDX_FAN_CTRL):     next_prdata[7:0] = fan_ctrl;
            10'(tta_pkg::IDX_TIMER):        next_prdata[7:0] = tbus.count;
            10'(tta_pkg::IDX_STATUS_TWO):   next_prdata[7:0] = status2;
            default: next_pslverr = 1'b1;
         endcase
      end else if (psel && penable && !pready) begin
         case (widx)
            10'(tta_pkg::IDX_CONFIG_THREE), 10'(tta_pkg::IDX_CONFIG_FOUR),
            10'(tta_pkg::IDX_LIMIT), 10'(tta_pkg::IDX_MASK_TWO),
            10'(tta_pkg::IDX_FAN_CTRL): next_pslverr = 1'b0;
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   // Fan override: a fan is running if its duty is nonzero and, in
   // automatic mode, the temperature is above the start point
   always_comb begin
      next_fan_duty = fan_duty_in;
      for (int i = 0; i < tta_pkg::NUM_FANS; i++) begin
         if (cfg3[tta_pkg::BIT_FULL_SPEED] && asserted
             && fan_duty_in[i*8 +: 8] != tta_pkg::DUTY_ZERO
             && (!fan_ctrl[tta_pkg::BIT_FAN_AUTO]
                 || fan_ctrl[tta_pkg::BIT_ABOVE_START]))
            next_fan_duty[i*8 +: 8] = tta_pkg::DUTY_FULL;
      end
   end

   // Alert held low while unmasked flag is set; flag clears only on read
   always_comb begin
      next_alert5_n  = !(cfg3[tta_pkg::BIT_ALERT_PIN5]
                      && next_status2[tta_pkg::BIT_LIMIT_FLAG]
                      && !mask2[tta_pkg::BIT_LIMIT_FLAG]);
      next_alert14_n = !(cfg4[tta_pkg::BIT_ALERT_PIN14]
                      && next_status2[tta_pkg::BIT_LIMIT_FLAG]
                      && !mask2[tta_pkg::BIT_LIMIT_FLAG]);
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cfg3            <= tta_pkg::REG_RESET;
         cfg4            <= tta_pkg::REG_RESET;
         limit           <= tta_pkg::REG_RESET;
         mask2           <= tta_pkg::REG_RESET;
         fan_ctrl        <= tta_pkg::REG_RESET;
         status2         <= tta_pkg::REG_RESET;
         prdata          <= 32'h0;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
         fan_duty_out    <= 24'h0;
         alert_pin5_n    <= 1'b1;
         alert_pin14_n   <= 1'b1;
         throttle_active <= 1'b0;
      end else if (ce) begin
         cfg3            <= next_cfg3;
         cfg4            <= next_cfg4;
         limit           <= next_limit;
         mask2           <= next_mask2;
         fan_ctrl        <= next_fan_ctrl;
         status2         <= next_status2;
         prdata          <= next_prdata;
         pready          <= next_pready;
         pslverr         <= next_pslverr;
         fan_duty_out    <= next_fan_duty;
         alert_pin5_n    <= next_alert5_n;
         alert_pin14_n   <= next_alert14_n;
         throttle_active <= asserted;
      end
   end
endmodule

// File: common/tta_pkg.sv
// Package: register map, field positions and timing constants
package tta_pkg;
   // Register word indices, paddr is index times four (printed offsets are not all multiples of four)
   localparam logic [7:0] IDX_MASK_TWO     = 8'h75;
   localparam logic [7:0] IDX_CONFIG_THREE = 8'h78;
   localparam logic [7:0] IDX_TIMER        = 8'h79;
   localparam logic [7:0] IDX_LIMIT        = 8'h7a;
   localparam logic [7:0] IDX_CONFIG_FOUR  = 8'h7d;
   localparam logic [7:0] IDX_STATUS_TWO   = 8'h42;
   localparam logic [7:0] IDX_FAN_CTRL     = 8'h80;
   localparam int         ADDR_SHIFT       = 2;

   // Field positions
   localparam int BIT_ALERT_PIN5    = 0;
   localparam int BIT_THR_ENABLE    = 1;
   localparam int BIT_FULL_SPEED    = 2;
   localparam int BIT_ALERT_PIN14   = 0;
   localparam int BIT_LIMIT_FLAG    = 5;
   localparam int BIT_FAN_AUTO      = 0;
   localparam int BIT_ABOVE_START   = 1;

   localparam int NUM_FANS = 3;
   localparam logic [7:0] DUTY_ZERO = 8'h00;
   localparam logic [7:0] DUTY_FULL = 8'hff;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] TIMER_MAX = 8'hff;
   localparam logic [7:0] TIMER_ONE = 8'h01;

   // One timer LSB is 22.76 ms
   localparam real LSB_TIME_MS = 22.76;
   localparam real CLK_MHZ     = 100.0;
   localparam int  LSB_CYCLES  = int'(LSB_TIME_MS * 1000.0 * CLK_MHZ);
endpackage

// File: common/tta_bus_if.sv
// Interface carrying decoded register accesses to the timer
interface tta_bus_if;
   logic       timer_read;
   logic [7:0] count;
   modport ctrl (output timer_read, input count);
   modport tmr  (input timer_read, output count);
endinterface

// File: design/tta_accum.sv
// Saturating, clear-on-read assertion time accumulator
module tta_accum #(
   parameter int LSB_CYC = 2276000
) (
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic ce,
   input  wire logic asserted,
   tta_bus_if.tmr    bus
);
   logic [7:0]  count;
   logic [7:0]  next_count;
   logic [31:0] tick;
   logic [31:0] next_tick;
   logic        first_seen;
   logic        next_first_seen;
   // Set once the first LSB period has passed behind the presence marker
   logic        tick_two;
   logic        next_tick_two;

   assign bus.count = count;

   always_comb begin
      next_count      = count;
      next_tick       = tick;
      next_first_seen = first_seen;
      if (bus.timer_read) begin
         // Read clears; an ongoing assertion re-marks bit 0 at once
         next_tick       = 32'h0;
         next_first_seen = asserted;
         next_count      = asserted ? tta_pkg::TIMER_ONE : 8'h00;
      end else if (asserted) begin
         if (!first_seen) begin
            next_first_seen = 1'b1;
            next_count      = tta_pkg::TIMER_ONE;
         end else if (count != tta_pkg::TIMER_MAX) begin
            if (tick == LSB_CYC - 1) begin
               next_tick = 32'h0;
               // Bit 0 is only a presence marker until the first two LSBs
               if (count == tta_pkg::TIMER_ONE && !tick_two)
                  next_count = count;
               else
                  next_count = count + 8'h01;
            end else begin
               next_tick = tick + 32'h1;
            end
         end
      end
   end

   // One-bit flag set by the first LSB period after the presence marker; a read clears it
   always_comb begin
      next_tick_two = tick_two;
      if (bus.timer_read)
         next_tick_two = 1'b0;
      else if (asserted && first_seen && tick == LSB_CYC - 1)
         next_tick_two = 1'b1;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count      <= 8'h00;
         tick       <= 32'h0;
         first_seen <= 1'b0;
         tick_two   <= 1'b0;
      end else if (ce) begin
         count      <= next_count;
         tick       <= next_tick;
         first_seen <= next_first_seen;
         tick_two   <= next_tick_two;
      end
   end
endmodule

// File: sim/tta_props.sv
// Port-level timing checks for the throttle monitor
module tta_props (
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        throttle_pin_in,
   input wire logic [23:0] fan_duty_in,
   input wire logic [23:0] fan_duty_out,
   input wire logic        alert_pin5_n,
   input wire logic        alert_pin14_n,
   input wire logic        throttle_active
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   chk_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait state");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   chk_fan_pass: assert property (!throttle_active && !$past(throttle_active)
      && !$past(throttle_active, 2) && $past(resetn)
      |-> fan_duty_out == $past(fan_duty_in))
      else $error("fan duty changed without throttle");
   chk_sync_delay: assert property ($rose(throttle_active)
      |-> !$past(throttle_pin_in, 2) || !$past(throttle_pin_in, 3))
      else $error("throttle seen without low pin");
   chk_alert_idle: assert property ($rose(resetn)
      |-> alert_pin5_n && alert_pin14_n)
      else $error("alert active after reset");
endmodule
bind tta_top tta_props u_props (.mclk, .resetn, .psel, .penable, .prdata,
   .pready, .pslverr, .throttle_pin_in, .fan_duty_in, .fan_duty_out,
   .alert_pin5_n, .alert_pin14_n, .throttle_active);

// File: sim/tta_hot_src.sv
// Far-side source of the active-low throttle line, idle high by pull-up
module tta_hot_src (
   input wire logic mclk,
   output logic     throttle_pin_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial throttle_pin_n = 1'b1;
   task automatic hold_low(input int n);
      @(posedge mclk);
      throttle_pin_n <= 1'b0;
      repeat (n) @(posedge mclk);
      throttle_pin_n <= 1'b1;
   endtask
endmodule

// File: sim/throttle_timer_alert_tb.sv
// Self-checking bench for the throttle monitor
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
   $display("MISMATCH at %0t got %h exp %h", $time, a, b); end end
module throttle_timer_alert_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        ce = 1;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic        pready, pslverr, thr_n, a5_n, a14_n, t_act;
   logic [23:0] fan_in = '0, fan_out, exp_fan;
   logic [32:0] q[$];
   logic [32:0] e;
   int          n_fail = 0, n_compared = 0;
   tta_hot_src src (.mclk(mclk), .throttle_pin_n(thr_n));
   tta_top #(.LSB_CYC(20)) DUT (.mclk(mclk), .resetn(resetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .throttle_pin_in(thr_n), .fan_duty_in(fan_in), .fan_duty_out(fan_out),
      .alert_pin5_n(a5_n), .alert_pin14_n(a14_n), .throttle_active(t_act));
   initial begin
      forever #5 mclk = ~mclk;
   end
   task automatic close_out;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Reads note {pslverr, prdata} as expected; writes note nothing
   task automatic apb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, input logic [32:0] x);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= 12'(idx) << 2;
      pwdata <= {24'h0, d};
      if (!w) q.push_back(x);
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(posedge mclk) begin
      if (pready === 1'b1 && !pwrite) begin
         e = q.pop_front();
         `CHK({pslverr, prdata}, e)
      end
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      close_out();
   end
   initial begin
      void'($urandom(50));
      fan_in <= {8'($urandom % 255 + 1), 8'($urandom % 255 + 1), 8'h00};
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      `CHK({a5_n, a14_n}, 2'b11)
      apb(0, tta_pkg::IDX_CONFIG_THREE, 0, {25'h0, tta_pkg::REG_RESET});
      apb(0, tta_pkg::IDX_CONFIG_FOUR, 0, {25'h0, tta_pkg::REG_RESET});
      apb(0, tta_pkg::IDX_LIMIT, 0, {25'h0, tta_pkg::REG_RESET});
      apb(0, 8'h3f, 0, {1'b1, 32'h0});
      fork
         src.hold_low(10);
         begin repeat (6) @(posedge mclk); `CHK(t_act, 1'b0) end
      join
      apb(0, tta_pkg::IDX_TIMER, 0, 33'h0);
      apb(1, tta_pkg::IDX_CONFIG_THREE, 8'h07, 0);
      apb(1, tta_pkg::IDX_CONFIG_FOUR, 8'h01, 0);
      apb(1, tta_pkg::IDX_LIMIT, 8'h01, 0);
      exp_fan = {8'hff, 8'hff, 8'h00};
      fork
         src.hold_low(45);
         begin
            repeat (10) @(posedge mclk);
            `CHK(t_act, 1'b1)
            `CHK(fan_out, exp_fan)
         end
      join
      src.hold_low(45);
      repeat (5) @(posedge mclk);
      `CHK({a5_n, a14_n}, 2'b00)
      apb(0, tta_pkg::IDX_TIMER, 0, 33'h4);
      apb(0, tta_pkg::IDX_TIMER, 0, 33'h0);
      apb(0, tta_pkg::IDX_STATUS_TWO, 0, 33'h20);
      apb(0, tta_pkg::IDX_STATUS_TWO, 0, 33'h0);
      repeat (2) @(posedge mclk);
      `CHK({a5_n, a14_n}, 2'b11)
      apb(1, tta_pkg::IDX_MASK_TWO, 8'h20, 0);
      apb(1, tta_pkg::IDX_LIMIT, 8'h00, 0);
      apb(1, tta_pkg::IDX_CONFIG_THREE, 8'h03, 0);
      fork
         src.hold_low(40);
         begin
            repeat (8) @(posedge mclk);
            `CHK(fan_out, fan_in)
            apb(0, tta_pkg::IDX_TIMER, 0, 33'h1);
            apb(0, tta_pkg::IDX_STATUS_TWO, 0, 33'h20);
            `CHK({a5_n, a14_n}, 2'b11)
         end
      join
      repeat (5) @(posedge mclk);
      apb(0, tta_pkg::IDX_TIMER, 0, 33'h1);
      apb(0, tta_pkg::IDX_STATUS_TWO, 0, 33'h20);
      src.hold_low(5300);
      repeat (5) @(posedge mclk);
      apb(0, tta_pkg::IDX_TIMER, 0, 33'hff);
      apb(0, tta_pkg::IDX_TIMER, 0, 33'h0);
      // Automatic mode: below start the fan ignores throttle, above it boosts
      apb(1, tta_pkg::IDX_CONFIG_THREE, 8'h07, 0);
      apb(1, tta_pkg::IDX_FAN_CTRL, 8'h01, 0);
      apb(0, tta_pkg::IDX_FAN_CTRL, 0, 33'h1);
      fan_in <= {8'($urandom % 255 + 1), 8'h00, 8'($urandom % 255 + 1)};
      fork
         src.hold_low(20);
         begin
            repeat (8) @(posedge mclk);
            `CHK(fan_out, fan_in)
            apb(1, tta_pkg::IDX_FAN_CTRL, 8'h03, 0);
            repeat (2) @(posedge mclk);
            `CHK(fan_out, {8'hff, 8'h00, 8'hff})
         end
      join
      repeat (3) @(posedge mclk);
      apb(0, tta_pkg::IDX_TIMER, 0, 33'h1);
      apb(0, tta_pkg::IDX_STATUS_TWO, 0, 33'h20);
      // Clock enable low: a throttle pulse must leave no trace
      ce <= 1'b0;
      fork
         src.hold_low(30);
         begin repeat (10) @(posedge mclk); `CHK(t_act, 1'b0) end
      join
      ce <= 1'b1;
      apb(0, tta_pkg::IDX_TIMER, 0, 33'h0);
      // Second reset in mid-run returns the routing to off
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      `CHK({a5_n, a14_n}, 2'b11)
      apb(0, tta_pkg::IDX_CONFIG_THREE, 0, 33'h0);
      apb(0, tta_pkg::IDX_FAN_CTRL, 0, 33'h0);
      repeat (3) @(posedge mclk);
      close_out();
   end
endmodule
